// >>> hw/rng_cfg.svh
// timing constants and reset values for the reset input and interrupt gate
`ifndef RNG_CFG_SVH
`define RNG_CFG_SVH
`define RNG_CLK_PERIOD_PS    8000
`define RNG_REJECT_TIME_PS   10000
`define RNG_PASS_TIME_PS     100000
// a pulse shorter than the reject time must never qualify: qualify only after
// strictly more cycles than fit into the reject time (rounded up)
`define RNG_REJECT_CYCLES    ((`RNG_REJECT_TIME_PS + `RNG_CLK_PERIOD_PS - 1) / `RNG_CLK_PERIOD_PS)
// a pulse longer than the pass time must qualify: longest time rounds down; the filter needs RNG_PASS_CYCLES + 1 low samples (104 ns)
`define RNG_PASS_CYCLES      (`RNG_PASS_TIME_PS / `RNG_CLK_PERIOD_PS)
`define RNG_SYNC_RESET_VAL   1'b1
`endif

// >>> hw/rng_pkg.sv
// types for the reset input and interrupt gate
package rng_pkg;
  typedef enum logic [1:0] {
    RNG_RUN      = 2'b00,
    RNG_PWR_DOWN = 2'b01
  } rng_pmode_t;
endpackage

// >>> hw/rng_sync.sv
// two-stage synchroniser for one level input
`timescale 1ns/1ps
module rng_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic din,
  output logic      dout
);
  logic meta_r;
  logic meta_nxt;
  logic dout_nxt;

  always_comb begin
    meta_nxt = din;
    dout_nxt = meta_r;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= RESET_VAL;
      dout   <= RESET_VAL;
    end else begin
      meta_r <= meta_nxt;
      dout   <= dout_nxt;
    end
  end
endmodule

// >>> hw/rng_top.sv
// reset input spike filter, interrupt edge trap and power-down gate
// How it works
// - qualified low reset input resets the device
// - low pulses under 10 ns are ignored
// - low pulses of 104 ns or more always pass
// - interrupt falling edge requests the trap routine
// - power-down with interrupt low enters power down
// - power-down with interrupt high keeps running
`timescale 1ns/1ps
`include "rng_cfg.svh"
module rng_top #(
  parameter int QUAL_CYCLES = `RNG_PASS_CYCLES
) (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        ext_reset_in_n,
  input  wire logic        nmi_in_n,
  input  wire logic        power_down_instr,
  output logic             dev_reset_n,
  output logic             nmi_trap,
  output rng_pkg::rng_pmode_t pmode,
  output logic             pwr_down_ignored
);
  import rng_pkg::*;

  localparam int CW = $clog2(QUAL_CYCLES + 1);
  localparam logic [CW-1:0] QUAL_MAX = CW'(QUAL_CYCLES);

  logic rst_a_r;
  logic rst_s_r;
  logic rst_n;

  // local reset release through two flops
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_a_r <= 1'b0;
      rst_s_r <= 1'b0;
    end else begin
      rst_a_r <= 1'b1;
      rst_s_r <= rst_a_r;
    end
  end
  assign rst_n = rst_s_r;

  logic ext_reset_in_n_s;
  logic nmi_s;

  rng_sync #(.RESET_VAL(`RNG_SYNC_RESET_VAL)) u_sync_rst (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .din     (ext_reset_in_n),
    .dout    (ext_reset_in_n_s)
  );

  rng_sync #(.RESET_VAL(`RNG_SYNC_RESET_VAL)) u_sync_nmi (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .din     (nmi_in_n),
    .dout    (nmi_s)
  );

  logic [CW-1:0] low_cnt_r;
  logic [CW-1:0] low_cnt_nxt;
  logic          dev_reset_nxt;
  logic          nmi_prev_r;
  logic          nmi_prev_nxt;
  logic          nmi_trap_nxt;
  rng_pmode_t    pmode_nxt;
  logic          ignored_nxt;

  // the filter counts consecutive low samples; a high sample restarts it, so a
  // glitch never accumulates. QUAL_CYCLES is far above the reject window.
  always_comb begin
    low_cnt_nxt   = low_cnt_r;
    dev_reset_nxt = dev_reset_n;
    if (ext_reset_in_n_s) begin
      low_cnt_nxt   = '0;
      dev_reset_nxt = 1'b1;
    end else if (low_cnt_r != QUAL_MAX) begin
      low_cnt_nxt = low_cnt_r + CW'(1);
    end else begin
      dev_reset_nxt = 1'b0;
    end
  end

  always_comb begin
    nmi_prev_nxt = nmi_s;
    nmi_trap_nxt = nmi_prev_r & ~nmi_s;
    pmode_nxt    = pmode;
    ignored_nxt  = 1'b0;
    if (!dev_reset_n) begin
      pmode_nxt = RNG_RUN;
    end else if (power_down_instr && pmode == RNG_RUN) begin
      if (!nmi_s) begin
        pmode_nxt = RNG_PWR_DOWN;
      end else begin
        ignored_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt_r        <= '0;
      dev_reset_n      <= 1'b1;
      nmi_prev_r       <= 1'b1;
      nmi_trap         <= 1'b0;
      pmode            <= RNG_RUN;
      pwr_down_ignored <= 1'b0;
    end else begin
      low_cnt_r        <= low_cnt_nxt;
      dev_reset_n      <= dev_reset_nxt;
      nmi_prev_r       <= nmi_prev_nxt;
      nmi_trap         <= nmi_trap_nxt;
      pmode            <= pmode_nxt;
      pwr_down_ignored <= ignored_nxt;
    end
  end

  sequence s_low_run;
    !ext_reset_in_n [*8];
  endsequence

  AST_GLITCH_REJECT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(ext_reset_in_n_s) && $past(ext_reset_in_n_s, 2) |-> dev_reset_n)
    else $error("short low pulse caused reset");

  AST_QUAL_RESET: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (low_cnt_r == QUAL_MAX) && !ext_reset_in_n_s |=> !dev_reset_n)
    else $error("qualified low did not reset");

  AST_LONG_PASS: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_low_run ##1 (!ext_reset_in_n [*5]) |-> ##[1:20] !dev_reset_n)
    else $error("long low pulse not passed");

  AST_RELEASE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ext_reset_in_n_s |=> dev_reset_n && low_cnt_r == '0)
    else $error("reset not released on high");

  AST_NMI_EDGE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $fell(nmi_in_n) |-> ##3 nmi_trap)
    else $error("falling edge gave no trap");

  AST_NMI_ONLY_EDGE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    nmi_trap |-> $past(nmi_in_n, 4) && !$past(nmi_in_n, 3))
    else $error("trap without falling edge");

  AST_PD_ENTER: assert property (@(posedge clk_sys) disable iff (!rst_n)
    power_down_instr && !nmi_s && dev_reset_n && pmode == RNG_RUN |=> pmode == RNG_PWR_DOWN)
    else $error("power down not entered");

  // a request with the interrupt pin high while running stays in run mode and raises pwr_down_ignored
  AST_PD_IGNORE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    power_down_instr && nmi_s && dev_reset_n && pmode == RNG_RUN
      |=> pmode == RNG_RUN && pwr_down_ignored)
    else $error("power down not ignored");

  // a single low sample on the pin between two high ones
  sequence s_pin_glitch;
    ext_reset_in_n ##1 !ext_reset_in_n ##1 ext_reset_in_n;
  endsequence

  // a power-down request that must be ignored
  sequence s_pd_req_high;
    power_down_instr && nmi_s && dev_reset_n && pmode == RNG_RUN;
  endsequence

  // the glitch reaches the filter two edges later and must leave reset idle
  AST_PIN_GLITCH: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_pin_glitch |-> ##3 dev_reset_n [*3])
    else $error("pin glitch caused reset");

  AST_RST_ONLY_LOW: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !dev_reset_n |-> !$past(ext_reset_in_n_s))
    else $error("reset without low sample");

  AST_RST_STANDS: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !dev_reset_n && !ext_reset_in_n_s |=> !dev_reset_n)
    else $error("reset dropped while pin low");

  // the counter saturates, so a long hold never wraps back to released
  AST_CNT_BOUND: assert property (@(posedge clk_sys) disable iff (!rst_n)
    low_cnt_r <= QUAL_MAX)
    else $error("filter counter out of range");

  AST_SYNC_RST: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ext_reset_in_n_s == $past(ext_reset_in_n, 2))
    else $error("reset pin not synchronised");

  AST_SYNC_NMI: assert property (@(posedge clk_sys) disable iff (!rst_n)
    nmi_s == $past(nmi_in_n, 2))
    else $error("interrupt pin not synchronised");

  // a falling edge needs a high sample first, so traps never come back to back
  AST_TRAP_PULSE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    nmi_trap |=> !nmi_trap)
    else $error("trap longer than one cycle");

  AST_PD_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pmode == RNG_PWR_DOWN && dev_reset_n |=> pmode == RNG_PWR_DOWN)
    else $error("power down left without reset");

  // power down is left only through a device reset
  AST_PD_WAKE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !dev_reset_n |=> pmode == RNG_RUN)
    else $error("reset did not wake from power down");

  AST_PD_ONLY_REQ: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pmode == RNG_PWR_DOWN && $past(pmode) == RNG_RUN
      |-> $past(power_down_instr) && !$past(nmi_s))
    else $error("power down without request");

  AST_PD_REQ_HIGH: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_pd_req_high |=> pmode != RNG_PWR_DOWN)
    else $error("power down entered with pin high");

  AST_IGN_CAUSE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pwr_down_ignored |-> $past(power_down_instr) && $past(nmi_s) && $past(dev_reset_n))
    else $error("ignore pulse without request");

  AST_IGN_RUN: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pwr_down_ignored |-> pmode == RNG_RUN)
    else $error("ignore pulse outside run mode");

  // only the two coded modes may ever appear on the output
  AST_PMODE_LEGAL: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pmode == RNG_RUN || pmode == RNG_PWR_DOWN)
    else $error("illegal power mode code");

  AST_TRAP_CAUSE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    nmi_trap |-> $past(nmi_prev_r) && !$past(nmi_s))
    else $error("trap without synchronised edge");
endmodule

// >>> verif/rng_board.sv
// board reset source and interrupt source model
`timescale 1ns/1ps
module rng_board (
  input  wire logic clk_sys,
  output logic      ext_reset_in_n,
  output logic      nmi_in_n
);
  // both pins are pulled up on the board, so idle is high
  initial ext_reset_in_n = 1'b1;
  initial nmi_in_n = 1'b1;
  task automatic rst_pulse(input int n);
    @(posedge clk_sys);
    #1 ext_reset_in_n = 1'b0;
    repeat (n) @(posedge clk_sys);
    #1 ext_reset_in_n = 1'b1;
  endtask
  task automatic nmi_level(input logic v);
    @(posedge clk_sys);
    #1 nmi_in_n = v;
  endtask
endmodule

// >>> verif/testbench.sv
// self-checking bench for the reset filter, trap and power-down gate
`timescale 1ns/1ps
module testbench;
  import rng_pkg::*;
  localparam int QUAL = 12;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic        power_down_instr = 1'b0;
  logic        ext_reset_in_n, nmi_in_n, dev_reset_n, nmi_trap, pwr_down_ignored;
  rng_pmode_t  pmode;
  int          err_count = 0;
  int          comparisons = 0;
  int          lows = 0, traps = 0, ign = 0, n;
  logic [15:0] lfsr = 16'h8982;
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    lows += (dev_reset_n === 1'b0);
    traps += (nmi_trap === 1'b1);
    ign += (pwr_down_ignored === 1'b1);
  end
  rng_board u_board (.clk_sys(clk_sys), .ext_reset_in_n(ext_reset_in_n), .nmi_in_n(nmi_in_n));
  rng_top #(.QUAL_CYCLES(QUAL)) u_dut (.clk_sys(clk_sys), .reset_n(reset_n),
    .ext_reset_in_n(ext_reset_in_n), .nmi_in_n(nmi_in_n), .power_down_instr(power_down_instr),
    .dev_reset_n(dev_reset_n), .nmi_trap(nmi_trap), .pmode(pmode),
    .pwr_down_ignored(pwr_down_ignored));
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (exp !== got) begin
      err_count++;
      $display("ERROR %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic wrap_up;
    $display("comparisons %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic pd(input int wait_n);
    @(posedge clk_sys);
    #1 power_down_instr = 1'b1;
    @(posedge clk_sys);
    #1 power_down_instr = 1'b0;
    repeat (wait_n) @(posedge clk_sys);
  endtask
  initial begin
    #20000;
    err_count++;
    wrap_up();
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    #1 reset_n = 1'b1;
    repeat (3) @(posedge clk_sys);
    // 8 ns glitches against runs well over the pass time
    for (int i = 0; i < 8; i++) begin
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      n = lfsr[0] ? 1 : QUAL + 3 + lfsr[4:1];
      lows = 0;
      u_board.rst_pulse(n);
      repeat (6) @(posedge clk_sys);
      check("reset_low", 32'(n > QUAL), 32'(lows > 0));
    end
    traps = 0;
    u_board.nmi_level(1'b0);
    repeat (6) @(posedge clk_sys);
    u_board.nmi_level(1'b1);
    repeat (6) @(posedge clk_sys);
    check("nmi_trap", 1, traps);
    u_board.nmi_level(1'b0);
    repeat (4) @(posedge clk_sys);
    pd(1);
    check("pmode", RNG_PWR_DOWN, 32'(pmode));
    u_board.rst_pulse(QUAL + 8);
    repeat (6) @(posedge clk_sys);
    check("pmode_wake", RNG_RUN, 32'(pmode));
    u_board.nmi_level(1'b1);
    repeat (4) @(posedge clk_sys);
    ign = 0;
    pd(2);
    check("ignored", 1, ign);
    check("pmode_run", RNG_RUN, 32'(pmode));
    wrap_up();
  end
endmodule
